// [rtl/snp_pkg.sv]
/*
 * Shared constants, state type and helper functions for the serial
 * nonvolatile memory access and write-protection block.
 * Assumes: an 8-bit status byte, a 32K x 8 array and a 15-bit word address.
 */
package snp_pkg;

    // ==========================================================
    // array geometry
    localparam int          SNP_ADDR_W       = 15;
    localparam int          SNP_DATA_W       = 8;
    localparam int          SNP_MEM_DEPTH    = 32768;
    localparam logic [14:0] SNP_ADDR_LAST    = 15'h7FFF;
    localparam logic [14:0] SNP_ADDR_FIRST   = 15'h0000;
    localparam logic [14:0] SNP_ADDR_STEP    = 15'h0001;
    localparam logic [14:0] SNP_PROT_QUARTER = 15'h6000;
    localparam logic [14:0] SNP_PROT_HALF    = 15'h4000;

    // ==========================================================
    // command opcodes
    localparam logic [7:0]  SNP_OP_SET_LATCH = 8'h06;
    localparam logic [7:0]  SNP_OP_CLR_LATCH = 8'h04;
    localparam logic [7:0]  SNP_OP_STAT_RD   = 8'h05;
    localparam logic [7:0]  SNP_OP_STAT_WR   = 8'h01;
    localparam logic [7:0]  SNP_OP_READ      = 8'h03;
    localparam logic [7:0]  SNP_OP_FAST_READ = 8'h0B;
    localparam logic [7:0]  SNP_OP_WRITE     = 8'h02;

    // ==========================================================
    // status layout and reset values
    localparam int          SNP_ST_PIN_EN    = 7;
    localparam int          SNP_ST_BP_HI     = 3;
    localparam int          SNP_ST_BP_LO     = 2;
    localparam int          SNP_ST_LATCH     = 1;
    localparam logic [7:0]  SNP_STATUS_RESET = 8'h00;
    localparam logic [1:0]  SNP_BP_RESET     = 2'h0;
    localparam logic [1:0]  SNP_BP_NONE      = 2'h0;
    localparam logic [1:0]  SNP_BP_QUARTER   = 2'h1;
    localparam logic [1:0]  SNP_BP_HALF      = 2'h2;
    localparam logic [2:0]  SNP_BIT_FIRST    = 3'h0;
    localparam logic [2:0]  SNP_BIT_LAST     = 3'h7;

    typedef enum logic [3:0] {
        SNP_S_OPCODE,
        SNP_S_ADDR_HI,
        SNP_S_ADDR_LO,
        SNP_S_DUMMY,
        SNP_S_RD_DATA,
        SNP_S_WR_DATA,
        SNP_S_STAT_OUT,
        SNP_S_STAT_IN,
        SNP_S_IGNORE
    } snp_state_t;

    // ==========================================================
    // helpers
    // true when the block-protect pair covers this word address
    function automatic logic snp_addr_protected(input logic [1:0] bp, input logic [14:0] addr);
        logic hit;
        hit = 1'b1;
        if (bp == SNP_BP_NONE)
            hit = 1'b0;
        else if (bp == SNP_BP_QUARTER)
            hit = (addr >= SNP_PROT_QUARTER);
        else if (bp == SNP_BP_HALF)
            hit = (addr >= SNP_PROT_HALF);
        return hit;
    endfunction : snp_addr_protected

    // assemble the status byte; unused positions read as zero
    function automatic logic [7:0] snp_status_byte(input logic pin_en, input logic [1:0] bp,
                                                   input logic latch);
        logic [7:0] st;
        st                = SNP_STATUS_RESET;
        st[SNP_ST_PIN_EN] = pin_en;
        st[SNP_ST_BP_HI]  = bp[1];
        st[SNP_ST_BP_LO]  = bp[0];
        st[SNP_ST_LATCH]  = latch;
        return st;
    endfunction : snp_status_byte

endpackage : snp_pkg

// [rtl/snp_mem_if.sv]
/*
 * Carrier between the serial command engine and the byte array.
 * Assumes: both ends run on the serial clock; read data is combinational.
 */
`timescale 1ns/1ps
interface snp_mem_if;
    logic        wr_en;
    logic [14:0] addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;

    modport ctrl  (output wr_en, output addr, output wr_data, input rd_data);
    modport store (input wr_en, input addr, input wr_data, output rd_data);
endinterface : snp_mem_if

// [rtl/snp_array.sv]
/*
 * 32K x 8 byte store built from flip-flops, one write and one read port.
 * Assumes: written on the rising serial clock edge; contents carry no reset,
 * since the array stands for nonvolatile storage.
 */
`timescale 1ns/1ps
module snp_array
    import snp_pkg::*;
(
    input wire logic sck,
    snp_mem_if.store mem
);

    logic [7:0] store_reg [SNP_MEM_DEPTH];

    // ==========================================================
    // byte write, committed on the edge that brings in the last bit
    always_ff @(posedge sck) begin
        if (mem.wr_en) begin
            store_reg[mem.addr] <= mem.wr_data;
        end
    end

    // read is combinational so the next byte is ready before the falling edge
    assign mem.rd_data = store_reg[mem.addr];

endmodule : snp_array

// [rtl/snp_top.sv]
/*
 * Serial slave command engine with status byte, write latch and block
 * protection, plus a system-clock mirror of the status byte.
 * Assumes: sck only toggles while cs_n is low (modes 0 and 3); the master
 * keeps its own ordering duties; clock is the 25 MHz system clock.
 */
// Contract
// [R1] status byte: pin enable, two protect bits, latch
// [R2] latch is clear after power-up
// [R3] status write never touches latch bit
// [R4] protect pair selects none, quarter, half, all
// [R5] protect bits persist; everything zero initially
// [R6] status write refused: pin enable, guard low
// [R7] guard pin never blocks array writes
// [R8] status read returns one byte, msb first
// [R9] status write updates bits, then clears latch
// [R10] master: latch set, guard high before status write
// [R11] master sets latch in separate frame first
// [R12] two address bytes, top bit ignored
// [R13] address increments per byte, wraps to zero
// [R14] each byte written at its eighth bit
// [R15] protected address stops increment, drops bytes
// [R16] chip select rise ends a write
// [R17] read data follows address, msb first, sequential
// [R18] all bytes shift msb first
// [R19] serial input ignored while driving read data
// [R20] fast read adds one dummy byte
// [R21] chip select rise ends read, releases output
// [R22] decode the seven listed opcodes
// [R23] latch clears at chip select rise after writes
// [R24] sample rising, drive falling edges
// [R25] unknown opcode: ignore rest, output stays released
// [R26] writes with latch clear change nothing
`timescale 1ns/1ps
module snp_top
    import snp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic       write_guard_pin_n,
    output logic            so,
    output logic            so_oe,
    output logic [7:0]      status_mirror,
    output logic            frame_end
);

    // ==========================================================
    // declarations
    snp_state_t  state_reg;
    snp_state_t  state_next;
    logic [2:0]  bit_cnt_reg;
    logic [6:0]  shift_reg;
    logic        is_fast_reg;
    logic        is_fast_next;
    logic        is_write_reg;
    logic        is_write_next;
    logic [14:0] addr_reg;
    logic [14:0] addr_next;

    logic        latch_reg;
    logic        latch_next;
    logic        clr_pend_reg;
    logic        clr_pend_next;
    logic        pin_en_reg;
    logic        pin_en_next;
    logic [1:0]  bp_reg;
    logic [1:0]  bp_next;
    logic        guard_meta_reg;
    logic        guard_sync_reg;

    logic        so_reg;
    logic        so_oe_reg;

    logic        cs_meta_reg;
    logic        cs_sync_reg;
    logic        cs_prev_reg;
    logic [7:0]  status_mirror_reg;
    logic        frame_end_reg;

    wire         frame_rst_n;
    wire         byte_done;
    wire  [7:0]  byte_in;
    wire         first_edge;
    wire         op_done;
    wire         addr_prot;
    wire         stat_wr_ok;
    wire         stat_commit;
    wire         wr_commit;
    wire         so_active;
    wire  [7:0]  status_now;
    wire  [7:0]  status_cross;
    wire  [7:0]  tx_byte;
    wire  [2:0]  tx_index;

    snp_mem_if mem_bus ();

    // ==========================================================
    // byte array
    snp_array u_array (
        .sck (sck),
        .mem (mem_bus.store)
    );

    // ==========================================================
    // frame decode terms
    // a raised chip select clears all frame state without a clock edge,
    // since the master may stop sck the moment the frame ends
    assign frame_rst_n = reset_n & ~cs_n;                               // [R16] [R21]
    assign byte_done   = (bit_cnt_reg == SNP_BIT_LAST);
    assign byte_in     = {shift_reg, si};                               // [R18] [R24]
    assign first_edge  = (state_reg == SNP_S_OPCODE) && (bit_cnt_reg == SNP_BIT_FIRST);
    assign op_done     = (state_reg == SNP_S_OPCODE) && byte_done;
    assign addr_prot   = snp_addr_protected(bp_reg, addr_reg);          // [R4]

    // guard pin counts only when pin enable is set; array writes never see it
    assign stat_wr_ok  = latch_reg && !(pin_en_reg && !guard_sync_reg); // [R6] [R26]
    assign stat_commit = (state_reg == SNP_S_STAT_IN) && byte_done && stat_wr_ok;
    assign wr_commit   = (state_reg == SNP_S_WR_DATA) && byte_done
                         && latch_reg && !addr_prot;                    // [R7] [R14] [R26]

    // ==========================================================
    // array port
    assign mem_bus.wr_en   = wr_commit;                                 // [R14]
    assign mem_bus.addr    = addr_reg;
    assign mem_bus.wr_data = byte_in;

    // ==========================================================
    // status views
    // latch seen by the system clock side already reflects a pending clear,
    // because that clear belongs to the frame that just closed
    assign status_now   = snp_status_byte(pin_en_reg, bp_reg, latch_reg);            // [R1]
    assign status_cross = snp_status_byte(pin_en_reg, bp_reg, latch_reg & ~clr_pend_reg); // [R23]

    // ==========================================================
    // transmit selection
    assign so_active = (state_reg == SNP_S_STAT_OUT) || (state_reg == SNP_S_RD_DATA);
    assign tx_byte   = (state_reg == SNP_S_STAT_OUT) ? status_now : mem_bus.rd_data; // [R8] [R17]
    assign tx_index  = SNP_BIT_LAST - bit_cnt_reg;                      // [R18]

    // ==========================================================
    // command sequencer next state
    always_comb begin
        state_next    = state_reg;
        is_fast_next  = is_fast_reg;
        is_write_next = is_write_reg;
        unique case (state_reg)
            SNP_S_OPCODE: begin
                if (byte_done) begin
                    case (byte_in)                                      // [R22]
                        SNP_OP_SET_LATCH: state_next = SNP_S_IGNORE;
                        SNP_OP_CLR_LATCH: state_next = SNP_S_IGNORE;
                        SNP_OP_STAT_RD:   state_next = SNP_S_STAT_OUT;
                        SNP_OP_STAT_WR:   state_next = SNP_S_STAT_IN;
                        SNP_OP_READ: begin
                            state_next = SNP_S_ADDR_HI;
                        end
                        SNP_OP_FAST_READ: begin
                            state_next   = SNP_S_ADDR_HI;
                            is_fast_next = 1'b1;                        // [R20]
                        end
                        SNP_OP_WRITE: begin
                            state_next    = SNP_S_ADDR_HI;
                            is_write_next = 1'b1;
                        end
                        // unknown codes lock the frame out until cs_n rises
                        default: state_next = SNP_S_IGNORE;             // [R25]
                    endcase
                end
            end
            SNP_S_ADDR_HI: begin
                if (byte_done) begin
                    state_next = SNP_S_ADDR_LO;                         // [R12]
                end
            end
            SNP_S_ADDR_LO: begin
                if (byte_done) begin
                    if (is_write_reg)
                        state_next = SNP_S_WR_DATA;
                    else if (is_fast_reg)
                        state_next = SNP_S_DUMMY;                       // [R20]
                    else
                        state_next = SNP_S_RD_DATA;                     // [R17]
                end
            end
            SNP_S_DUMMY: begin
                if (byte_done) begin
                    state_next = SNP_S_RD_DATA;                         // [R20]
                end
            end
            SNP_S_RD_DATA: begin
                state_next = SNP_S_RD_DATA;                             // [R19]
            end
            SNP_S_WR_DATA: begin
                state_next = SNP_S_WR_DATA;
            end
            SNP_S_STAT_OUT: begin
                if (byte_done) begin
                    state_next = SNP_S_IGNORE;                          // [R8]
                end
            end
            SNP_S_STAT_IN: begin
                if (byte_done) begin
                    state_next = SNP_S_IGNORE;
                end
            end
            SNP_S_IGNORE: begin
                state_next = SNP_S_IGNORE;                              // [R25]
            end
        endcase
    end

    // ==========================================================
    // word address: loaded from two bytes, stepped per data byte except at a protected write address
    always_comb begin
        addr_next = addr_reg;
        if ((state_reg == SNP_S_ADDR_HI) && byte_done) begin
            addr_next = {byte_in[6:0], addr_reg[7:0]};                  // [R12]
        end else if ((state_reg == SNP_S_ADDR_LO) && byte_done) begin
            addr_next = {addr_reg[14:8], byte_in};
        end else if ((state_reg == SNP_S_RD_DATA) && byte_done) begin
            addr_next = addr_reg + SNP_ADDR_STEP;                       // [R13]
        end else if ((state_reg == SNP_S_WR_DATA) && byte_done && !addr_prot) begin
            // a protected address freezes the pointer, so every later byte
            // lands on the same protected word and is dropped as well
            addr_next = addr_reg + SNP_ADDR_STEP;                       // [R13] [R15]
        end
    end

    // ==========================================================
    // write latch: set by its own command, cleared at the next frame's
    // first edge after a clearing command, which is as good as the chip
    // select rise because no access can look at it in between
    always_comb begin
        latch_next    = latch_reg;
        clr_pend_next = clr_pend_reg;
        if (first_edge && clr_pend_reg) begin
            latch_next    = 1'b0;                                       // [R23]
            clr_pend_next = 1'b0;
        end
        if (op_done) begin
            if (byte_in == SNP_OP_SET_LATCH) begin
                latch_next = 1'b1;
            end
            if ((byte_in == SNP_OP_CLR_LATCH) || (byte_in == SNP_OP_STAT_WR)
                || (byte_in == SNP_OP_WRITE)) begin
                clr_pend_next = 1'b1;                                   // [R9] [R23]
            end
        end
    end

    // ==========================================================
    // status write: only pin enable and protect bits take the data
    assign pin_en_next = stat_commit ? byte_in[SNP_ST_PIN_EN] : pin_en_reg;            // [R9]
    assign bp_next     = stat_commit ? byte_in[SNP_ST_BP_HI:SNP_ST_BP_LO] : bp_reg;    // [R3]

    // ==========================================================
    // frame state on rising sck, cleared whenever cs_n is high
    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state_reg    <= SNP_S_OPCODE;
            bit_cnt_reg  <= SNP_BIT_FIRST;
            shift_reg    <= SNP_STATUS_RESET[6:0];
            is_fast_reg  <= 1'b0;
            is_write_reg <= 1'b0;
            addr_reg     <= SNP_ADDR_FIRST;
        end else begin
            state_reg    <= state_next;
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;                         // [R24]
            shift_reg    <= byte_in[6:0];                               // [R18]
            is_fast_reg  <= is_fast_next;
            is_write_reg <= is_write_next;
            addr_reg     <= addr_next;
        end
    end

    // ==========================================================
    // persistent state, cleared only by the device reset; protect bits
    // model nonvolatile cells and start from the factory zero
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            latch_reg    <= 1'b0;                                       // [R2]
            clr_pend_reg <= 1'b0;
            pin_en_reg   <= SNP_STATUS_RESET[SNP_ST_PIN_EN];            // [R5]
            bp_reg       <= SNP_BP_RESET;                               // [R5]
        end else begin
            latch_reg    <= latch_next;
            clr_pend_reg <= clr_pend_next;
            pin_en_reg   <= pin_en_next;
            bp_reg       <= bp_next;
        end
    end

    // ==========================================================
    // guard pin synchroniser on sck; it settles during the opcode byte,
    // well before a status write can commit
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            guard_meta_reg <= 1'b0;
            guard_sync_reg <= 1'b0;
        end else begin
            guard_meta_reg <= write_guard_pin_n;
            guard_sync_reg <= guard_meta_reg;
        end
    end

    // ==========================================================
    // serial output launched on falling sck; a high cs_n releases it at once
    always_ff @(negedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so_reg    <= 1'b0;
            so_oe_reg <= 1'b0;                                          // [R21] [R25]
        end else begin
            so_reg    <= tx_byte[tx_index];                             // [R24]
            so_oe_reg <= so_active;
        end
    end

    assign so    = so_reg;
    assign so_oe = so_oe_reg;

    // ==========================================================
    // system clock side: chip select synchroniser and end-of-frame detect
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    // ==========================================================
    // status mirror: captured on the third clock edge after cs_n rises, when sck has
    // stopped and the serial side cannot change; a master that restarts
    // a frame before any clock edge samples cs_n high leaves the older mirror in place
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_mirror_reg <= SNP_STATUS_RESET;
            frame_end_reg     <= 1'b0;
        end else begin
            frame_end_reg <= cs_sync_reg & ~cs_prev_reg;
            if (cs_sync_reg && !cs_prev_reg) begin
                status_mirror_reg <= status_cross;
            end
        end
    end

    assign status_mirror = status_mirror_reg;
    assign frame_end     = frame_end_reg;

endmodule : snp_top

// [verif/snp_monitor.sv]
/*
 * Port checker for snp_top, bound to every instance.
 * Assumes the mirror settles a few clocks after chip select rises.
 */
`timescale 1ns/1ps
module snp_monitor
    import snp_pkg::*;
(
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic       write_guard_pin_n,
    input wire logic       so_oe,
    input wire logic [7:0] status_mirror,
    input wire logic       frame_end
);
    // ======================================
    // system clock side
    oe_deselect_a: assert property (@(posedge clock) disable iff (!reset_n)
        cs_n |-> !so_oe) else $error("output enabled while deselected");
    end_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        frame_end |=> !frame_end) else $error("frame end longer than one clock");
    end_follows_a: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(cs_n) |-> ##[1:5] frame_end) else $error("no frame end after deselect");
    fixed_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        status_mirror[6:4] == 3'h0 && !status_mirror[0]) else $error("fixed status bits set");
    mirror_at_end_a: assert property (@(posedge clock) disable iff (!reset_n)
        $changed(status_mirror) |-> frame_end) else $error("mirror moved outside frame end");
    latch_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        $changed(status_mirror[7:2]) |-> $past(status_mirror[1])) else $error("status changed without latch");
    guard_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        $changed(status_mirror[7:2]) |-> !$past(status_mirror[7]) || $past(write_guard_pin_n, 4))
        else $error("status changed while guarded");
    // ======================================
    // serial clock side: a driven byte is always whole
    byte_whole_a: assert property (@(posedge sck) disable iff (!reset_n || cs_n)
        $rose(so_oe) |-> so_oe [*8]) else $error("output byte cut short");
    cover property (@(posedge clock) disable iff (!reset_n) frame_end);
    cover property (@(posedge sck) disable iff (!reset_n) $rose(so_oe));
    cover property (@(posedge clock) disable iff (!reset_n) $changed(status_mirror[7:2]));
endmodule : snp_monitor

bind snp_top snp_monitor i_snp_monitor (.clock, .reset_n, .sck, .cs_n, .write_guard_pin_n,
    .so_oe, .status_mirror, .frame_end);

// [verif/snp_master.sv]
/*
 * Serial bus master model in mode 0; sck stands still between frames.
 * Assumes the device drives so only while so_oe is high.
 */
`timescale 1ns/1ps
module snp_master
(
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    logic [7:0] rx_q [$];

    // ======================================
    // idle levels from time zero
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // one frame, msb first; released output reads back as z
    task run(input logic [7:0] tx [$]);
        logic [7:0] b;
        rx_q = {};
        cs_n = 1'b0;
        #5;
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                si = tx[k][i];
                #3;
                sck = 1'b1;
                b[i] = so_oe ? so : 1'bz;
                #3;
                sck = 1'b0;
            end
            rx_q.push_back(b);
        end
        #2;
        cs_n = 1'b1;
        si = ~si; // stale data would hide a missed release
        #320; // gap keeps the mirror's sync from merging frames
    endtask : run
endmodule : snp_master

// [verif/tb.sv]
/*
 * Self-checking bench for snp_top with a serial master model.
 * Assumes array contents start unknown, so every byte read was written first.
 */
`timescale 1ns/1ps
module tb
    import snp_pkg::*;
;
    logic       clock = 1'b0;
    logic       reset_n;
    logic       write_guard_pin_n;
    logic       sck;
    logic       cs_n;
    logic       si;
    logic       so;
    logic       so_oe;
    logic [7:0] status_mirror;
    logic       frame_end;
    int         n_errors = 0;
    int         num_checks = 0;

    always #20 clock = ~clock;

    snp_top i_snp_top (.clock, .reset_n, .sck, .cs_n, .si, .write_guard_pin_n, .so, .so_oe,
        .status_mirror, .frame_end);
    snp_master i_snp_master (.sck, .cs_n, .si, .so, .so_oe);

    // ======================================
    // helpers
    task wrap_up;
        if (n_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task xf(input logic [7:0] tx [$]);
        i_snp_master.run(tx);
    endtask : xf
    task wr(input logic [7:0] tx [$]);
        xf('{SNP_OP_SET_LATCH});
        xf(tx);
    endtask : wr
    task guard(input logic v);
        @(negedge clock) write_guard_pin_n = v;
    endtask : guard
    task st(input logic [7:0] e);
        xf('{SNP_OP_STAT_RD, 8'hFF});
        chk("status", e, i_snp_master.rx_q[1]);
        chk("mirror", e, status_mirror);
    endtask : st
    task rd(input logic [7:0] op, input logic [15:0] a, input logic [7:0] e [$]);
        logic [7:0] q [$];
        int n;
        q = '{op, a[15:8], a[7:0]};
        if (op == SNP_OP_FAST_READ)
            q.push_back(8'hFF);
        n = q.size();
        foreach (e[k]) q.push_back(8'hA5);
        xf(q);
        foreach (e[k]) chk("read", e[k], i_snp_master.rx_q[n + k]);
    endtask : rd

    // ======================================
    // scenarios
    task t_burst;
        st(8'h00);
        wr('{SNP_OP_WRITE, 8'hFF, 8'hFF, 8'h11, 8'h22});
        rd(SNP_OP_READ, 16'h7FFF, '{8'h11, 8'h22});
        rd(SNP_OP_FAST_READ, 16'hFFFF, '{8'h11, 8'h22});
        st(8'h00);
    endtask : t_burst
    task t_latch;
        xf('{SNP_OP_WRITE, 8'h00, 8'h00, 8'h77});
        rd(SNP_OP_READ, 16'h0000, '{8'h22});
        xf('{SNP_OP_SET_LATCH});
        st(8'h02);
        xf('{SNP_OP_CLR_LATCH});
        st(8'h00);
    endtask : t_latch
    task t_status;
        guard(1'b1);
        wr('{SNP_OP_STAT_WR, 8'hFF});
        st(8'h8C);
        guard(1'b0);
        wr('{SNP_OP_STAT_WR, 8'h00});
        st(8'h8C);
        guard(1'b1);
        wr('{SNP_OP_STAT_WR, 8'h00});
        st(8'h00);
    endtask : t_status
    task t_protect;
        wr('{SNP_OP_WRITE, 8'h5F, 8'hFF, 8'hAA, 8'hBB, 8'hCC});
        guard(1'b0);
        wr('{SNP_OP_STAT_WR, 8'h04});
        st(8'h04);
        wr('{SNP_OP_WRITE, 8'h5F, 8'hFF, 8'h01, 8'h02, 8'h03});
        rd(SNP_OP_READ, 16'h5FFF, '{8'h01, 8'hBB, 8'hCC});
        wr('{SNP_OP_STAT_WR, 8'h0C});
        wr('{SNP_OP_WRITE, 8'h00, 8'h00, 8'h55});
        rd(SNP_OP_READ, 16'h0000, '{8'h22});
        guard(1'b1);
    endtask : t_protect
    task t_bad_op;
        xf('{8'hFF, SNP_OP_STAT_RD, 8'h00});
        chk("released", 8'hZZ, i_snp_master.rx_q[2]);
    endtask : t_bad_op

    // ======================================
    // main sequence and watchdog
    initial begin
        reset_n = 1'b0;
        write_guard_pin_n = 1'b1;
        repeat (10) @(posedge clock);
        @(negedge clock) reset_n = 1'b1;
        t_burst;
        t_latch;
        t_status;
        t_protect;
        t_bad_op;
        wrap_up;
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up;
    end
endmodule : tb
